/* File: core/pfk_pkg.sv */
package pfk_pkg;
	// key population
	localparam int NCTRL = 7;
	localparam int NBASE = 3;
	localparam int NUSER = 12;
	localparam int NKEY = 19;
	// timing: one millisecond tick drives every slow counter
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam int CTRL_DROP_MS = 100;
	localparam logic [6:0] CTRL_DROP_TICKS = 7'(CTRL_DROP_MS / TICK_MS);
	localparam int DEBOUNCE_MS = 4;
	localparam logic [2:0] DEB_TICKS = 3'(DEBOUNCE_MS / TICK_MS);
	// register byte addresses
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_FLASH = 8'h08;
	localparam logic [7:0] ADDR_STATE = 8'h0c;
	localparam logic [7:0] ADDR_EVT_STAT = 8'h10;
	localparam logic [7:0] ADDR_EVT_CLR = 8'h14;
	localparam logic [7:0] ADDR_EVT_EN = 8'h18;
	localparam logic [7:0] ADDR_HOLD_BASE = 8'h40;
	localparam logic [7:0] ADDR_HOLD_LAST = 8'h6c;
	// configuration bit positions and reset values
	localparam int CFG_TWELVE = 0;
	localparam int CFG_BREAKER = 1;
	localparam int CFG_LOG = 2;
	localparam logic [2:0] CFG_RST = 3'h4;
	localparam logic [23:0] MODE_RST = 24'h000000;
	localparam logic [15:0] FLASH_RST = 16'h03e8;
	localparam logic [15:0] HOLD_RST = 16'h0000;
	// state register field positions
	localparam int ST_USER = 7;
	localparam int ST_MSG = 19;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// user key behaviour setting, two bits per key
	typedef enum logic [1:0]
	{
		MODE_DISABLED = 2'h0,
		MODE_SELF_RESET = 2'h1,
		MODE_LATCHED = 2'h2
	} pfk_mode_e;

	// axi4-lite master to slave
	typedef struct packed
	{
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} pfk_axil_req_s;

	// axi4-lite slave to master
	typedef struct packed
	{
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pfk_axil_rsp_s;

	// message selection handed to the display
	typedef struct packed
	{
		logic show;
		logic [3:0] key;
		logic inactive;
	} pfk_msg_s;
endpackage : pfk_pkg

/* File: core/pfk_faceplate_keys.sv */
// Overview of operation
// - control key operand follows held key
// - control operand lingers 100 ms after release
// - log control press, never its release
// - one key at a time honoured
// - keys four to seven need twelve-key option
// - breaker manual mode silences first three keys
// - each user key gives On and Off
// - disabled user key: both operands low
// - self-reset: On follows press, Off complements
// - latched: each press toggles, complementary operands
// - latched state kept in non-volatile storage
// - LED lit exactly while On asserted
// - self-reset hold extension stretches On and LED
// - title plus on message when entering On
// - off message only latched On-to-Off
// - messages shown for shared flash time
`timescale 1ns/10ps
`default_nettype none
module pfk_faceplate_keys
#(
	parameter int TICK_CYCLES = pfk_pkg::TICK_CYCLES_DEF
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register bus
	input wire pfk_pkg::pfk_axil_req_s axiReq,
	output pfk_pkg::pfk_axil_rsp_s axiRsp,
	// key contacts, high while pressed
	input wire logic [pfk_pkg::NCTRL-1:0] ctrlKeyPin,
	input wire logic [pfk_pkg::NUSER-1:0] userKeyPin,
	// logic operands
	output logic [pfk_pkg::NCTRL-1:0] controlKeyActive,
	output logic [pfk_pkg::NUSER-1:0] userOn,
	output logic [pfk_pkg::NUSER-1:0] userOff,
	output logic [pfk_pkg::NUSER-1:0] userLed,
	// non-volatile storage of latched states
	output logic [pfk_pkg::NUSER-1:0] nvStore,
	input wire logic [pfk_pkg::NUSER-1:0] nvRecall,
	input wire logic nvRecallValid,
	// display message selection and interrupt
	output pfk_pkg::pfk_msg_s keyMsg,
	output logic irq
);
	import pfk_pkg::*;

	// whole module state
	typedef struct packed
	{
		logic [NKEY-1:0] syncA; // first synchroniser stage
		logic [NKEY-1:0] syncB; // second synchroniser stage
		logic [NKEY-1:0] deb; // debounced pressed level
		logic [NKEY-1:0][2:0] debCnt; // stable-difference counters
		logic [15:0] tickCnt; // millisecond prescaler
		logic tick; // one-cycle millisecond strobe
		logic ownerValid; // a key currently holds the panel
		logic [4:0] ownerIdx; // which key holds it
		logic [NKEY-1:0] honPrev; // honoured level last cycle
		logic [NCTRL-1:0][6:0] dropCnt; // control dropout timers
		logic [NCTRL-1:0] ctrlAct; // control operands
		logic [NUSER-1:0] latched; // latched key states
		logic [NUSER-1:0][15:0] extCnt; // hold extension timers
		logic [NUSER-1:0] onOp; // On operands
		logic [NUSER-1:0] offOp; // Off operands
		logic loaded; // stored states recalled
		logic [15:0] flashCnt; // message time left in ticks
		pfk_msg_s msg; // current message
		logic [2:0] cfg; // configuration bits
		logic [2*NUSER-1:0] mode; // behaviour settings
		logic [15:0] flashMs; // shared message time
		logic [NUSER-1:0][15:0] holdExt; // per-key hold extension
		logic [NKEY-1:0] evtStat; // sticky events
		logic [NKEY-1:0] evtEn; // interrupt enables
		logic awHeld; // write address captured
		logic [7:0] awAddr;
		logic wHeld; // write data captured
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pfk_state_s;

	pfk_state_s s_reg;
	pfk_state_s s_next;

	// byte-lane merge of a bus write into a stored word
	function automatic logic [31:0] pfk_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (d & m);
	endfunction : pfk_merge

	// read decode, reserved bits read as zero
	function automatic logic [32:0] pfk_read(input pfk_state_s st, input logic [7:0] a);
		logic [32:0] r;
		logic [3:0] k;
		r = {1'b1, 32'h00000000};
		k = 4'((a - ADDR_HOLD_BASE) >> 2);
		if (a == ADDR_CFG)
			r = {1'b0, 29'h0, st.cfg};
		else if (a == ADDR_MODE)
			r = {1'b0, 8'h00, st.mode};
		else if (a == ADDR_FLASH)
			r = {1'b0, 16'h0000, st.flashMs};
		else if (a == ADDR_STATE)
			r = {1'b0, 12'h000, st.msg.show, st.onOp, st.ctrlAct};
		else if (a == ADDR_EVT_STAT)
			r = {1'b0, 13'h0000, st.evtStat};
		else if (a == ADDR_EVT_CLR)
			r = {1'b0, 32'h00000000};
		else if (a == ADDR_EVT_EN)
			r = {1'b0, 13'h0000, st.evtEn};
		else if (a >= ADDR_HOLD_BASE && a <= ADDR_HOLD_LAST && a[1:0] == 2'h0)
			r = {1'b0, 16'h0000, st.holdExt[k]};
		return r;
	endfunction : pfk_read

	// next-state logic for keys, timers, messages and bus
	always_comb
	begin
		logic [NKEY-1:0] elig;
		logic [NKEY-1:0] rise;
		logic [NKEY-1:0] hon;
		logic [NKEY-1:0] evSet;
		logic [NKEY-1:0] evClr;
		logic [NUSER-1:0] onN;
		logic started;
		logic [32:0] rd;
		logic [3:0] k;
		logic [31:0] mw;
		pfk_mode_e md;
		elig = '0;
		rise = '0;
		hon = '0;
		evSet = '0;
		evClr = '0;
		onN = '0;
		started = 1'b0;
		rd = '0;
		k = '0;
		mw = '0;
		md = MODE_DISABLED;
		s_next = s_reg;
		// contacts cross into the clock domain through two flops
		s_next.syncA = {userKeyPin, ctrlKeyPin};
		s_next.syncB = s_reg.syncA;
		// millisecond strobe
		s_next.tick = 1'b0;
		if (s_reg.tickCnt == 16'(TICK_CYCLES - 1))
		begin
			s_next.tickCnt = '0;
			s_next.tick = 1'b1;
		end
		else
			s_next.tickCnt = s_reg.tickCnt + 16'h0001;
		// debounce: a change must persist for several ticks
		for (int i = 0; i < NKEY; i++)
		begin
			if (s_reg.syncB[i] == s_reg.deb[i])
				s_next.debCnt[i] = '0;
			else if (s_reg.tick)
			begin
				if (s_reg.debCnt[i] == DEB_TICKS - 3'h1)
				begin
					s_next.deb[i] = s_reg.syncB[i];
					s_next.debCnt[i] = '0;
					rise[i] = s_reg.syncB[i];
				end
				else
					s_next.debCnt[i] = s_reg.debCnt[i] + 3'h1;
			end
		end
		// which keys exist and respond at all
		for (int i = 0; i < NCTRL; i++)
			elig[i] = (i < NBASE) || s_reg.cfg[CFG_TWELVE];
		for (int i = 0; i < NUSER; i++)
			elig[NCTRL+i] = (s_reg.mode[2*i+:2] == MODE_SELF_RESET) ||
				(s_reg.mode[2*i+:2] == MODE_LATCHED);
		// panel ownership: a press counts only while no key holds the panel
		if (s_reg.ownerValid)
		begin
			if (!s_reg.deb[s_reg.ownerIdx] || !elig[s_reg.ownerIdx])
				s_next.ownerValid = 1'b0;
		end
		else
		begin
			for (int i = NKEY - 1; i >= 0; i--)
			begin
				if (rise[i] && elig[i])
				begin
					s_next.ownerValid = 1'b1;
					s_next.ownerIdx = 5'(i);
				end
			end
		end
		for (int i = 0; i < NKEY; i++)
			hon[i] = s_reg.ownerValid && (s_reg.ownerIdx == 5'(i)) && s_reg.deb[i];
		s_next.honPrev = hon;

		// control keys with dropout stretch
		for (int i = 0; i < NCTRL; i++)
		begin
			if (i < NBASE && s_reg.cfg[CFG_BREAKER])
			begin
				s_next.dropCnt[i] = '0;
				s_next.ctrlAct[i] = 1'b0;
			end
			else
			begin
				if (hon[i])
					s_next.dropCnt[i] = CTRL_DROP_TICKS;
				else if (s_reg.tick && s_reg.dropCnt[i] != '0)
					s_next.dropCnt[i] = s_reg.dropCnt[i] - 7'h01;
				s_next.ctrlAct[i] = hon[i] || (s_next.dropCnt[i] != '0);
				evSet[i] = hon[i] && !s_reg.honPrev[i] && s_reg.cfg[CFG_LOG];
			end
		end

		// recall latched states once, after reset release
		if (!s_reg.loaded && nvRecallValid)
		begin
			s_next.latched = nvRecall;
			s_next.loaded = 1'b1;
		end

		// user keys
		for (int i = 0; i < NUSER; i++)
		begin
			md = pfk_mode_e'(s_reg.mode[2*i+:2]);
			case (md)
				MODE_SELF_RESET:
				begin
					if (hon[NCTRL+i])
						s_next.extCnt[i] = s_reg.holdExt[i];
					else if (s_reg.tick && s_reg.extCnt[i] != '0)
						s_next.extCnt[i] = s_reg.extCnt[i] - 16'h0001;
					onN[i] = hon[NCTRL+i] || (s_next.extCnt[i] != '0);
				end
				MODE_LATCHED:
				begin
					s_next.extCnt[i] = '0;
					if (hon[NCTRL+i] && !s_reg.honPrev[NCTRL+i])
						s_next.latched[i] = !s_next.latched[i];
					onN[i] = s_next.latched[i];
				end
				default:
				begin
					s_next.extCnt[i] = '0;
					onN[i] = 1'b0;
				end
			endcase
			s_next.onOp[i] = onN[i];
			s_next.offOp[i] = elig[NCTRL+i] && !onN[i];
			evSet[NCTRL+i] = (onN[i] != s_reg.onOp[i]) && s_reg.cfg[CFG_LOG];
		end

		// message selection, lowest key wins a same-cycle clash
		if (s_reg.tick && s_reg.flashCnt != '0)
			s_next.flashCnt = s_reg.flashCnt - 16'h0001;
		if (s_reg.msg.show && s_reg.flashCnt == '0)
			s_next.msg.show = 1'b0;
		for (int i = NUSER - 1; i >= 0; i--)
		begin
			md = pfk_mode_e'(s_reg.mode[2*i+:2]);
			if (onN[i] && !s_reg.onOp[i])
			begin
				started = 1'b1;
				s_next.msg.key = 4'(i);
				s_next.msg.inactive = 1'b0;
			end
			else if (md == MODE_LATCHED && s_reg.onOp[i] && !onN[i])
			begin
				started = 1'b1;
				s_next.msg.key = 4'(i);
				s_next.msg.inactive = 1'b1;
			end
		end
		if (started)
		begin
			s_next.msg.show = 1'b1;
			s_next.flashCnt = s_reg.flashMs;
		end

		// bus: capture write address and data in either order
		if (axiReq.awvalid && !s_reg.awHeld && !s_reg.bvalid)
		begin
			s_next.awHeld = 1'b1;
			s_next.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && !s_reg.wHeld && !s_reg.bvalid)
		begin
			s_next.wHeld = 1'b1;
			s_next.wData = axiReq.wdata;
			s_next.wStrb = axiReq.wstrb;
		end
		if (s_reg.bvalid && axiReq.bready)
			s_next.bvalid = 1'b0;

		// perform a write once both halves are held
		if (s_reg.awHeld && s_reg.wHeld)
		begin
			s_next.awHeld = 1'b0;
			s_next.wHeld = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			k = 4'((s_reg.awAddr - ADDR_HOLD_BASE) >> 2);
			if (s_reg.awAddr == ADDR_CFG)
			begin
				mw = pfk_merge({29'h0, s_reg.cfg}, s_reg.wData, s_reg.wStrb);
				s_next.cfg = mw[2:0];
			end
			else if (s_reg.awAddr == ADDR_MODE)
			begin
				mw = pfk_merge({8'h00, s_reg.mode}, s_reg.wData, s_reg.wStrb);
				s_next.mode = mw[23:0];
			end
			else if (s_reg.awAddr == ADDR_FLASH)
			begin
				mw = pfk_merge({16'h0000, s_reg.flashMs}, s_reg.wData, s_reg.wStrb);
				s_next.flashMs = mw[15:0];
			end
			else if (s_reg.awAddr == ADDR_EVT_CLR)
			begin
				mw = pfk_merge(32'h00000000, s_reg.wData, s_reg.wStrb);
				evClr = mw[NKEY-1:0];
			end
			else if (s_reg.awAddr == ADDR_EVT_EN)
			begin
				mw = pfk_merge({13'h0000, s_reg.evtEn}, s_reg.wData, s_reg.wStrb);
				s_next.evtEn = mw[NKEY-1:0];
			end
			else if (s_reg.awAddr >= ADDR_HOLD_BASE && s_reg.awAddr <= ADDR_HOLD_LAST &&
				s_reg.awAddr[1:0] == 2'h0)
			begin
				mw = pfk_merge({16'h0000, s_reg.holdExt[k]}, s_reg.wData, s_reg.wStrb);
				s_next.holdExt[k] = mw[15:0];
			end
			else if (s_reg.awAddr != ADDR_STATE && s_reg.awAddr != ADDR_EVT_STAT)
				s_next.bresp = RESP_SLVERR; // unmapped
		end

		// a new event beats a clear in the same cycle
		s_next.evtStat = (s_reg.evtStat & ~evClr) | evSet;

		// read channel
		if (s_reg.rvalid && axiReq.rready)
			s_next.rvalid = 1'b0;
		if (axiReq.arvalid && !s_reg.rvalid)
		begin
			rd = pfk_read(s_reg, axiReq.araddr);
			s_next.rvalid = 1'b1;
			s_next.rdata = rd[31:0];
			s_next.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
		end
	end

	// single state register; timers clear on reset, settings load their reset values
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_reg <= '0;
			s_reg.cfg <= CFG_RST;
			s_reg.mode <= MODE_RST;
			s_reg.flashMs <= FLASH_RST;
			s_reg.holdExt <= {NUSER{HOLD_RST}};
		end
		else
			s_reg <= s_next;
	end

	// outputs; handshakes are combinational from state
	assign axiRsp.awready = !s_reg.awHeld && !s_reg.bvalid;
	assign axiRsp.wready = !s_reg.wHeld && !s_reg.bvalid;
	assign axiRsp.bvalid = s_reg.bvalid;
	assign axiRsp.bresp = s_reg.bresp;
	assign axiRsp.arready = !s_reg.rvalid;
	assign axiRsp.rvalid = s_reg.rvalid;
	assign axiRsp.rdata = s_reg.rdata;
	assign axiRsp.rresp = s_reg.rresp;
	assign controlKeyActive = s_reg.ctrlAct;
	assign userOn = s_reg.onOp;
	assign userOff = s_reg.offOp;
	assign userLed = s_reg.onOp;
	assign nvStore = s_reg.latched;
	assign keyMsg = s_reg.msg;
	// interrupt stays high while any enabled event is pending
	assign irq = |(s_reg.evtStat & s_reg.evtEn);
endmodule : pfk_faceplate_keys
`default_nettype wire

/* File: tb/pfk_props.sv */
`timescale 1ns/10ps
`default_nettype none
module pfk_props
#(
	parameter int TICK_CYCLES = 20
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register bus
	input wire pfk_pkg::pfk_axil_req_s axiReq,
	input wire pfk_pkg::pfk_axil_rsp_s axiRsp,
	// keys and operands
	input wire logic [6:0] ctrlKeyPin,
	input wire logic [11:0] userKeyPin,
	input wire logic [6:0] controlKeyActive,
	input wire logic [11:0] userOn,
	input wire logic [11:0] userOff,
	input wire logic [11:0] userLed,
	input wire logic nvRecallValid
);
	import pfk_pkg::*;
	// dropout window, one tick of slack below, eight ticks above
	localparam int DMIN = (CTRL_DROP_MS - 1) * TICK_CYCLES;
	localparam int DMAX = (CTRL_DROP_MS + 8) * TICK_CYCLES;
	int relCnt_reg;
	int relCnt_next;
	// cycles since the honoured control contact opened
	always_comb
	begin
		relCnt_next = relCnt_reg + 1;
		if (!(|controlKeyActive) || |(ctrlKeyPin & controlKeyActive))
			relCnt_next = 0;
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			relCnt_reg <= 0;
		else
			relCnt_reg <= relCnt_next;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// answers left waiting on the master
	sequence bWait;
		axiRsp.bvalid && !axiReq.bready;
	endsequence
	sequence rWait;
		axiRsp.rvalid && !axiReq.rready;
	endsequence
	ledFollows_a: assert property (userLed == userOn)
		else $error("led differs from on operand");
	opsExclusive_a: assert property ((userOn & userOff) == 0)
		else $error("on and off operands together");
	resetQuiet_a: assert property ($rose(rst_b) |-> !(|{controlKeyActive, userOn, userOff}))
		else $error("operand high out of reset");
	ctrlRise_a: assert property ((controlKeyActive & ~$past(controlKeyActive)
		& ~$past(ctrlKeyPin, 3)) == 0) else $error("control operand without press");
	ctrlFall_a: assert property ((~controlKeyActive & $past(controlKeyActive)
		& $past(ctrlKeyPin, 3)) == 0) else $error("control operand dropped while held");
	dropMin_a: assert property ((~controlKeyActive & $past(controlKeyActive)) != 0
		|-> relCnt_reg >= DMIN) else $error("control dropout too short");
	dropMax_a: assert property (|controlKeyActive |-> relCnt_reg < DMAX)
		else $error("control dropout too long");
	userRise_a: assert property ((userOn & ~$past(userOn) & ~$past(userKeyPin, 2)) == 0
		|| $past(nvRecallValid)) else $error("user operand rose without press");
	respHold_a: assert property (bWait |=> axiRsp.bvalid && $stable(axiRsp.bresp))
		else $error("write answer withdrawn");
	readHold_a: assert property (rWait |=> axiRsp.rvalid && $stable(axiRsp.rdata))
		else $error("read answer withdrawn");
endmodule : pfk_props
bind pfk_faceplate_keys pfk_props #(.TICK_CYCLES(TICK_CYCLES)) u_pfk_props
(
	.clk, .rst_b, .axiReq, .axiRsp, .ctrlKeyPin, .userKeyPin,
	.controlKeyActive, .userOn, .userOff, .userLed, .nvRecallValid
);
`default_nettype wire

/* File: tb/pfk_operator.sv */
`timescale 1ns/10ps
`default_nettype none
module pfk_operator
(
	// clock
	input wire logic clk,
	// contacts, high while pressed
	output logic [6:0] ctrlKeyPin,
	output logic [11:0] userKeyPin
);
	import pfk_pkg::*;
	// control contacts low, user contacts low
	logic [18:0] contact = '0;
	assign ctrlKeyPin = contact[6:0];
	assign userKeyPin = contact[18:7];
	// contact chatters once before settling, so debounce is exercised
	task automatic push(input int k, input logic lv);
		int n;
		for (n = 0; n < 4; n++)
		begin
			@(posedge clk);
			contact[k] <= (n == 1) ? !lv : lv;
		end
	endtask : push
endmodule : pfk_operator
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pfk_pkg::*;
	// row: config, key, operands held, soon after release, long after
	typedef struct packed
	{
		logic [2:0] cfg;
		logic [4:0] key;
		logic [18:0] held;
		logic [18:0] soon;
		logic [18:0] late;
	} pfk_row_s;
	// user keys 0, 1 and 4 are enabled by the mode word below
	localparam logic [11:0] EN = 12'h013;
	logic clk;
	logic rst_b = 1'b0;
	pfk_axil_req_s axiReq = '0;
	pfk_axil_rsp_s axiRsp;
	logic [6:0] ctrlKeyPin;
	logic [11:0] userKeyPin;
	logic [6:0] controlKeyActive;
	logic [11:0] userOn;
	logic [11:0] userOff;
	logic [11:0] userLed;
	logic [11:0] nvStore;
	logic [11:0] nvRecall = 12'h000;
	logic nvRecallValid = 1'b0;
	pfk_msg_s keyMsg;
	logic irq;
	int errors = 0;
	int comparisons = 0;
	int i;
	pfk_row_s rows [11] = '{{3'h5, 5'h00, 19'h1, 19'h1, 19'h0}, {3'h5, 5'h06, 19'h40, 19'h40, 19'h0},
		{3'h4, 5'h05, 19'h0, 19'h0, 19'h0}, {3'h7, 5'h01, 19'h0, 19'h0, 19'h0},
		{3'h7, 5'h03, 19'h8, 19'h8, 19'h0}, {3'h5, 5'h07, 19'h80, 19'h0, 19'h0},
		{3'h5, 5'h08, 19'h100, 19'h100, 19'h100}, {3'h5, 5'h08, 19'h0, 19'h0, 19'h0},
		{3'h5, 5'h09, 19'h0, 19'h0, 19'h0}, {3'h5, 5'h0a, 19'h0, 19'h0, 19'h0},
		{3'h5, 5'h0b, 19'h800, 19'h800, 19'h0}};
	logic [7:0] rdAddr [6] = '{ADDR_CFG, ADDR_MODE, ADDR_FLASH, ADDR_HOLD_BASE, ADDR_EVT_EN, 8'h20};
	logic [31:0] rdVal [6] = '{32'h4, 32'h0, 32'h3e8, 32'h0, 32'h0, 32'h0};
	pfk_faceplate_keys #(.TICK_CYCLES(20)) u_pfk_faceplate_keys
	(
		.clk, .rst_b, .axiReq, .axiRsp, .ctrlKeyPin, .userKeyPin, .controlKeyActive,
		.userOn, .userOff, .userLed, .nvStore, .nvRecall, .nvRecallValid, .keyMsg, .irq
	);
	pfk_operator u_pfk_operator (.clk, .ctrlKeyPin, .userKeyPin);
	// 20 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// a wait that ran out ends the run
	task automatic bail();
		errors++;
		tally_and_finish();
	endtask : bail
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// one bus access; ready lines go up only once the answer is seen
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] rsp);
		logic aw, w, ar, v, rdy;
		logic [31:0] dat;
		logic [1:0] r;
		int n;
		@(posedge clk);
		axiReq.awvalid <= wr;
		axiReq.wvalid <= wr;
		axiReq.arvalid <= !wr;
		axiReq.awaddr <= a;
		axiReq.araddr <= a;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hf;
		for (n = 0; n < 50; n++)
		begin
			@(negedge clk);
			aw = axiRsp.awready;
			w = axiRsp.wready;
			ar = axiRsp.arready;
			v = wr ? axiRsp.bvalid : axiRsp.rvalid;
			rdy = wr ? axiReq.bready : axiReq.rready;
			r = wr ? axiRsp.bresp : axiRsp.rresp;
			dat = axiRsp.rdata;
			@(posedge clk);
			if (aw)
				axiReq.awvalid <= 1'b0;
			if (w)
				axiReq.wvalid <= 1'b0;
			if (ar)
				axiReq.arvalid <= 1'b0;
			if (v && rdy)
				break;
			axiReq.bready <= wr && v;
			axiReq.rready <= !wr && v;
		end
		axiReq.bready <= 1'b0;
		axiReq.rready <= 1'b0;
		if (n == 50)
			bail();
		check(32'(r), 32'(rsp));
		if (!wr)
			check(dat, d);
	endtask : bus
	task automatic waitShow();
		int n;
		for (n = 0; n < 400 && keyMsg.show !== 1'b1; n++)
			@(negedge clk);
		if (n == 400)
			bail();
	endtask : waitShow
	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		// reset values, an unmapped read, a write to the read-only state, an unmapped write
		for (i = 0; i < 6; i++)
			bus(1'b0, rdAddr[i], rdVal[i], (i == 5) ? RESP_SLVERR : RESP_OKAY);
		bus(1'b1, ADDR_STATE, 32'hffffffff, RESP_OKAY);
		bus(1'b0, ADDR_STATE, 32'h0, RESP_OKAY);
		bus(1'b1, 8'h24, 32'h1, RESP_SLVERR);
		bus(1'b1, ADDR_MODE, 32'h1c9, RESP_OKAY);
		bus(1'b1, 8'h50, 32'ha, RESP_OKAY);
		bus(1'b1, ADDR_FLASH, 32'h5, RESP_OKAY);
		bus(1'b1, ADDR_EVT_EN, 32'h7ffff, RESP_OKAY);
		$display("registers done");
		// ordinary presses from the table
		for (i = 0; i < 11; i++)
		begin
			bus(1'b1, ADDR_CFG, 32'(rows[i].cfg), RESP_OKAY);
			u_pfk_operator.push(rows[i].key, 1'b1);
			cyc(200);
			check(32'({userOn, controlKeyActive}), 32'(rows[i].held));
			check(32'(userOff), 32'(EN & ~rows[i].held[18:7]));
			check(32'(userLed), 32'(rows[i].held[18:7]));
			u_pfk_operator.push(rows[i].key, 1'b0);
			cyc(150);
			check(32'({userOn, controlKeyActive}), 32'(rows[i].soon));
			cyc(2400);
			check(32'({userOn, controlKeyActive}), 32'(rows[i].late));
			$display("row %0d done", i);
		end
		// second key while the first is held is never honoured
		u_pfk_operator.push(0, 1'b1);
		cyc(200);
		u_pfk_operator.push(7, 1'b1);
		cyc(200);
		u_pfk_operator.push(0, 1'b0);
		cyc(300);
		check(32'(userOn), 32'h0);
		check(32'(controlKeyActive), 32'h1);
		u_pfk_operator.push(7, 1'b0);
		cyc(2400);
		$display("one key test done");
		// press logs an event, release does not; interrupt masked and cleared
		bus(1'b1, ADDR_EVT_CLR, 32'h7ffff, RESP_OKAY);
		check(32'(irq), 32'h0);
		u_pfk_operator.push(2, 1'b1);
		cyc(200);
		bus(1'b0, ADDR_EVT_STAT, 32'h4, RESP_OKAY);
		check(32'(irq), 32'h1);
		bus(1'b1, ADDR_EVT_EN, 32'h0, RESP_OKAY);
		check(32'(irq), 32'h0);
		bus(1'b1, ADDR_EVT_CLR, 32'h4, RESP_OKAY);
		bus(1'b1, ADDR_EVT_EN, 32'h7ffff, RESP_OKAY);
		u_pfk_operator.push(2, 1'b0);
		cyc(2400);
		bus(1'b0, ADDR_EVT_STAT, 32'h0, RESP_OKAY);
		check(32'(irq), 32'h0);
		$display("event test done");
		// messages: latched on, latched off, self-reset
		u_pfk_operator.push(8, 1'b1);
		waitShow();
		check(32'(keyMsg), 32'({1'b1, 4'h1, 1'b0}));
		cyc(60);
		check(32'(keyMsg.show), 32'h1);
		check(32'(nvStore), 32'h2);
		cyc(80);
		check(32'(keyMsg.show), 32'h0);
		u_pfk_operator.push(8, 1'b0);
		cyc(300);
		u_pfk_operator.push(8, 1'b1);
		waitShow();
		check(32'(keyMsg), 32'({1'b1, 4'h1, 1'b1}));
		u_pfk_operator.push(8, 1'b0);
		cyc(300);
		u_pfk_operator.push(7, 1'b1);
		waitShow();
		check(32'(keyMsg), 32'({1'b1, 4'h0, 1'b0}));
		u_pfk_operator.push(7, 1'b0);
		for (i = 0; i < 400 && !(keyMsg.show && keyMsg.inactive); i++)
			@(negedge clk);
		check(32'(i), 32'h190);
		$display("message test done");
		// reset in mid-run, then restore a latched state
		cyc(1);
		rst_b <= 1'b0;
		cyc(4);
		rst_b <= 1'b1;
		cyc(2);
		check(32'(userOn), 32'h0);
		bus(1'b1, ADDR_MODE, 32'h1c9, RESP_OKAY);
		nvRecall <= 12'h002;
		nvRecallValid <= 1'b1;
		cyc(10);
		check(32'(userOn), 32'h2);
		check(32'(userOff), 32'h011);
		check(32'(nvStore), 32'h002);
		$display("restore test done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
